// file: src/ims_pkg.sv
// Operation
// - Start, Repeated Start, Stop show one-hot control patterns 00001, 00010, 00100
// - Reception and acknowledge show one-hot patterns 01000 and 10000
// - Control bits zero: transmit flag high while sending a byte, else low
// - Setting start enable begins a Start condition
// - Setting restart enable begins a Repeated Start condition
// - Setting stop enable begins a Stop condition
// - Setting receive enable begins reception of one byte
// - Setting ack enable sends the level chosen by the ack level bit
// - Writing transmit data starts shifting that byte out
// - Reading receive data clears the receive buffer full flag
// - Each finished master event raises the master event interrupt
// - Control bit writes ignored while any event runs, no queuing
// - Transmit write during another event sets collision flag, buffer kept
// - Eighth falling clock of reception: clear enable, load byte unless buffer still full and unread, set full
package ims_pkg;
   localparam int AW = 3;
   localparam int DW = 16;

   // ***********************************
   // Register offsets
   // ***********************************
   localparam logic [2:0] ADDR_CTL = 3'h0;
   localparam logic [2:0] ADDR_STAT = 3'h1;
   localparam logic [2:0] ADDR_TX = 3'h2;
   localparam logic [2:0] ADDR_RX = 3'h3;
   localparam logic [2:0] ADDR_BRG = 3'h4;

   // ***********************************
   // Field positions
   // ***********************************
   localparam int BIT_START = 0;
   localparam int BIT_RSTART = 1;
   localparam int BIT_STOP = 2;
   localparam int BIT_RECV = 3;
   localparam int BIT_ACK = 4;
   localparam int CTL_ACKLVL = 5;
   localparam int ST_TBF = 0;
   localparam int ST_RBF = 1;
   localparam int ST_OV = 6;
   localparam int ST_WCOL = 7;
   localparam int ST_TRX = 14;
   localparam int ST_SLAVE_ACK_RECEIVED = 15;

   // ***********************************
   // Patterns and reset values
   // ***********************************
   localparam logic [4:0] PAT_IDLE = 5'h00;
   localparam logic [4:0] PAT_START = 5'h01;
   localparam logic [4:0] PAT_RSTART = 5'h02;
   localparam logic [4:0] PAT_STOP = 5'h04;
   localparam logic [4:0] PAT_RECV = 5'h08;
   localparam logic [4:0] PAT_ACK = 5'h10;
   localparam logic [8:0] BRG_RST = 9'h004;
   localparam logic [3:0] LAST_DATA = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   typedef struct packed {
      logic tx;
      logic ackLvl;
      logic [4:0] ev;
      logic [8:0] brg;
      logic [7:0] data;
   } ims_cmd_t;

   typedef struct packed {
      logic slave_ack_received;
      logic [7:0] rxByte;
   } ims_res_t;

   typedef enum logic [5:0] {
      L_IDLE = 6'h01,
      L_START = 6'h02,
      L_RSTART = 6'h04,
      L_STOP = 6'h08,
      L_BYTE = 6'h10,
      L_ACK = 6'h20
   } ims_lstate_t;
endpackage : ims_pkg

// file: src/ims_evt_sync.sv
`timescale 1ns/1ps
// ***********************************
// Toggle event crossing
// ***********************************
module ims_evt_sync
(
   input wire logic src_clk,
   input wire logic src_rst_b,
   input wire logic srcPulse,
   input wire logic dst_clk,
   input wire logic dst_rst_b,
   output logic dstPulse
);
   import ims_pkg::*;

   logic tog_r;
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge src_clk)
   begin
      if (!src_rst_b)
         tog_r <= 1'b0;
      else
         tog_r <= tog_r ^ srcPulse;
   end

   // Events must be spaced by a few destination clocks
   always_ff @(posedge dst_clk)
   begin
      if (!dst_rst_b)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= tog_r;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign dstPulse = s2_r ^ s3_r;
endmodule : ims_evt_sync

// file: src/ims_msg_seq.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module ims_msg_seq
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ims_pkg::AW-1:0] regAddr,
   input wire logic [ims_pkg::DW-1:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [ims_pkg::DW-1:0] rdData,
   output logic master_event_irq,
   input wire logic link_clk,
   input wire logic serial_clock_line_in,
   output logic serial_clock_line_out,
   output logic serial_clock_line_oe,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe
);
   import ims_pkg::*;

   // ***********************************
   // Core domain state
   // ***********************************
   ims_cmd_t cmd_r;
   ims_cmd_t cmdNxt;
   ims_res_t res;
   logic ackLvl_r;
   logic [8:0] brg_r;
   logic [7:0] rxData_r;
   logic rxFull_r;
   logic ov_r;
   logic wcol_r;
   logic slave_ack_received_r;
   logic [DW-1:0] rdData_r;
   logic [DW-1:0] statWord;
   logic doneCore;
   logic startPulse;

   wire busy = cmd_r.tx | (|cmd_r.ev);
   wire wrCtl = wrStb && (regAddr == ADDR_CTL);
   wire wrStat = wrStb && (regAddr == ADDR_STAT);
   wire wrTx = wrStb && (regAddr == ADDR_TX);
   wire wrBrg = wrStb && (regAddr == ADDR_BRG);
   wire rdRx = rdStb && (regAddr == ADDR_RX);
   // Only one event per request; multi-bit writes are dropped
   wire ctlGo = wrCtl && !busy && $onehot(wrData[4:0]);
   wire txGo = wrTx && !busy;
   wire txCol = wrTx && busy;
   wire rxDone = doneCore && cmd_r.ev[BIT_RECV];
   wire rxLoad = rxDone && (!rxFull_r || rdRx);
   wire clrWcol = wrStat && wrData[ST_WCOL];
   wire clrOv = wrStat && wrData[ST_OV];
   wire [DW-1:0] ctlWord = {10'h000, ackLvl_r, cmd_r.ev};
   wire [DW-1:0] rxWord = {8'h00, rxData_r};
   wire [DW-1:0] txWord = {8'h00, cmd_r.data};
   wire [DW-1:0] brgWord = {7'h00, brg_r};
   wire [DW-1:0] rdMux = (regAddr == ADDR_CTL) ? ctlWord :
                         (regAddr == ADDR_STAT) ? statWord :
                         (regAddr == ADDR_TX) ? txWord :
                         (regAddr == ADDR_RX) ? rxWord :
                         (regAddr == ADDR_BRG) ? brgWord : 16'h0000;

   always_comb
   begin
      statWord = 16'h0000;
      statWord[ST_TBF] = cmd_r.tx;
      statWord[ST_RBF] = rxFull_r;
      statWord[ST_OV] = ov_r;
      statWord[ST_WCOL] = wcol_r;
      statWord[ST_TRX] = cmd_r.tx;
      statWord[ST_SLAVE_ACK_RECEIVED] = slave_ack_received_r;
   end

   // ***********************************
   // Event issue and completion
   // ***********************************
   always_comb
   begin
      cmdNxt = cmd_r;
      if (doneCore)
      begin
         cmdNxt.ev = PAT_IDLE;
         cmdNxt.tx = 1'b0;
      end
      else if (ctlGo)
      begin
         cmdNxt.ev = wrData[4:0];
         cmdNxt.ackLvl = wrData[CTL_ACKLVL];
         cmdNxt.brg = brg_r;
      end
      else if (txGo)
      begin
         cmdNxt.tx = 1'b1;
         cmdNxt.data = wrData[7:0];
         cmdNxt.brg = brg_r;
      end
   end

   // Busy blocks control writes, so events never queue
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         cmd_r <= '0;
      else
         cmd_r <= cmdNxt;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ackLvl_r <= 1'b0;
         brg_r <= BRG_RST;
      end
      else
      begin
         if (wrCtl && !busy)
            ackLvl_r <= wrData[CTL_ACKLVL];
         if (wrBrg && !busy)
            brg_r <= wrData[8:0];
      end
   end

   // Set wins over clear on every flag
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rxFull_r <= 1'b0;
         ov_r <= 1'b0;
         wcol_r <= 1'b0;
      end
      else
      begin
         rxFull_r <= rxDone | (rxFull_r & ~rdRx);
         ov_r <= (rxDone & rxFull_r & ~rdRx) | (ov_r & ~clrOv);
         wcol_r <= txCol | (wcol_r & ~clrWcol);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rxData_r <= 8'h00;
         slave_ack_received_r <= 1'b0;
      end
      else
      begin
         if (rxLoad)
            rxData_r <= res.rxByte;
         if (doneCore && cmd_r.tx)
            slave_ack_received_r <= res.slave_ack_received;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         rdData_r <= 16'h0000;
      else
         rdData_r <= rdStb ? rdMux : 16'h0000;
   end

   assign rdData = rdData_r;
   assign startPulse = ctlGo | txGo;
   assign master_event_irq = doneCore;

   // ***********************************
   // Link domain
   // ***********************************
   logic lrst1_r;
   logic lrst_b;
   logic sclS1_r;
   logic sclS2_r;
   logic sdaS1_r;
   logic sdaS2_r;
   logic goLink;
   ims_lstate_t st_r;
   ims_lstate_t stNxt;
   logic [1:0] ph_r;
   logic [1:0] phNxt;
   logic [3:0] bit_r;
   logic [3:0] bitNxt;
   logic [7:0] sh_r;
   logic [7:0] shNxt;
   logic [8:0] brgCnt_r;
   logic [8:0] brgNxt;
   logic sclLow_r;
   logic sclNxt;
   logic sdaLow_r;
   logic sdaNxt;
   logic ack_r;
   logic ackNxt;
   logic done_r;
   logic sdaHold_r;
   logic fin;

   always_ff @(posedge link_clk)
   begin
      lrst1_r <= rst_b;
      lrst_b <= lrst1_r;
      sclS1_r <= serial_clock_line_in;
      sclS2_r <= sclS1_r;
      sdaS1_r <= serial_data_line_in;
      sdaS2_r <= sdaS1_r;
   end

   // Released clock held low by a slave pauses the baud timer
   wire stretch = !sclLow_r && !sclS2_r;
   wire tick = (brgCnt_r == 9'h000) && !stretch;
   wire isRx = cmd_r.ev[BIT_RECV];
   wire [7:0] shIn = {sh_r[6:0], sdaS2_r};
   wire [3:0] lastBit = isRx ? LAST_DATA : ACK_SLOT;

   assign brgNxt = goLink ? cmd_r.brg :
                   stretch ? brgCnt_r :
                   tick ? cmd_r.brg : brgCnt_r - 9'h001;

   always_comb
   begin
      stNxt = st_r;
      phNxt = ph_r;
      bitNxt = bit_r;
      shNxt = sh_r;
      sclNxt = sclLow_r;
      sdaNxt = sdaLow_r;
      ackNxt = ack_r;
      fin = 1'b0;
      case (st_r)
         L_IDLE:
            if (goLink)
            begin
               phNxt = 2'h0;
               bitNxt = 4'h0;
               shNxt = cmd_r.data;
               if (cmd_r.ev[BIT_START])
               begin
                  stNxt = L_START;
                  sclNxt = 1'b0;
                  sdaNxt = 1'b0;
               end
               else if (cmd_r.ev[BIT_RSTART])
               begin
                  stNxt = L_RSTART;
                  sclNxt = 1'b1;
               end
               else if (cmd_r.ev[BIT_STOP])
               begin
                  stNxt = L_STOP;
                  sclNxt = 1'b1;
                  sdaNxt = 1'b1;
               end
               else if (cmd_r.ev[BIT_ACK])
               begin
                  stNxt = L_ACK;
                  sdaNxt = ~cmd_r.ackLvl;
               end
               else
               begin
                  stNxt = L_BYTE;
                  sdaNxt = !isRx && !cmd_r.data[7];
               end
            end
         L_START:
            if (tick)
            begin
               phNxt = ph_r + 2'h1;
               if (ph_r == 2'h0)
                  sdaNxt = 1'b1;
               else
               begin
                  sclNxt = 1'b1;
                  fin = 1'b1;
               end
            end
         L_RSTART:
            if (tick)
            begin
               phNxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0: sdaNxt = 1'b0;
                  2'h1: sclNxt = 1'b0;
                  2'h2: sdaNxt = 1'b1;
                  default:
                  begin
                     sclNxt = 1'b1;
                     fin = 1'b1;
                  end
               endcase
            end
         L_STOP:
            if (tick)
            begin
               phNxt = ph_r + 2'h1;
               if (ph_r == 2'h0)
                  sclNxt = 1'b0;
               else
               begin
                  sdaNxt = 1'b0;
                  fin = 1'b1;
               end
            end
         L_ACK:
            if (tick)
            begin
               phNxt = ph_r + 2'h1;
               if (ph_r == 2'h0)
                  sclNxt = 1'b0;
               else
               begin
                  sclNxt = 1'b1;
                  sdaNxt = 1'b0;
                  fin = 1'b1;
               end
            end
         L_BYTE:
            if (tick)
            begin
               phNxt = {1'b0, ~ph_r[0]};
               if (!ph_r[0])
                  sclNxt = 1'b0;
               else
               begin
                  // Sample just before the falling edge
                  sclNxt = 1'b1;
                  bitNxt = bit_r + 4'h1;
                  if (bit_r == ACK_SLOT)
                     ackNxt = sdaS2_r;
                  else
                     shNxt = shIn;
                  if (bit_r == lastBit)
                  begin
                     sdaNxt = 1'b0;
                     fin = 1'b1;
                  end
                  else
                     sdaNxt = !isRx && (bit_r != LAST_DATA) && !shIn[7];
               end
            end
         default:
            stNxt = L_IDLE;
      endcase
      if (fin)
         stNxt = L_IDLE;
   end

   always_ff @(posedge link_clk)
   begin
      if (!lrst_b)
      begin
         st_r <= L_IDLE;
         ph_r <= 2'h0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         brgCnt_r <= BRG_RST;
      end
      else
      begin
         st_r <= stNxt;
         ph_r <= phNxt;
         bit_r <= bitNxt;
         sh_r <= shNxt;
         brgCnt_r <= brgNxt;
      end
   end

   always_ff @(posedge link_clk)
   begin
      if (!lrst_b)
      begin
         sclLow_r <= 1'b0;
         sdaLow_r <= 1'b0;
         sdaHold_r <= 1'b0;
         ack_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         sclLow_r <= sclNxt;
         sdaLow_r <= sdaNxt;
         // Data trails the clock line by one clock; only Start, Repeated Start and Stop change it under a high clock
         sdaHold_r <= sdaLow_r;
         ack_r <= ackNxt;
         done_r <= fin;
      end
   end

   // Result stays put until the next command, so it crosses quasi-static
   assign res.rxByte = sh_r;
   assign res.slave_ack_received = ack_r;
   assign serial_clock_line_out = 1'b0;
   assign serial_clock_line_oe = sclLow_r;
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = sdaHold_r;

   ims_evt_sync u_go
   (
      .src_clk(core_clk),
      .src_rst_b(rst_b),
      .srcPulse(startPulse),
      .dst_clk(link_clk),
      .dst_rst_b(lrst_b),
      .dstPulse(goLink)
   );

   ims_evt_sync u_done
   (
      .src_clk(link_clk),
      .src_rst_b(lrst_b),
      .srcPulse(done_r),
      .dst_clk(core_clk),
      .dst_rst_b(rst_b),
      .dstPulse(doneCore)
   );

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_done;
      doneCore && busy;
   endsequence
   sequence s_rx_end;
      doneCore && (cmd_r.ev == PAT_RECV) && !rxFull_r && !rdRx;
   endsequence

   property p_start;
      ctlGo && wrData[BIT_START] |=> cmd_r.ev == PAT_START && !cmd_r.tx;
   endproperty
   property p_restart;
      ctlGo && wrData[BIT_RSTART] |=> cmd_r.ev == PAT_RSTART;
   endproperty
   property p_stop;
      ctlGo && wrData[BIT_STOP] |=> cmd_r.ev == PAT_STOP;
   endproperty
   property p_recv;
      ctlGo && wrData[BIT_RECV] |=> cmd_r.ev == PAT_RECV && ctlWord[4:0] == PAT_RECV;
   endproperty
   property p_ack;
      ctlGo && wrData[BIT_ACK] |=> cmd_r.ev == PAT_ACK && cmd_r.ackLvl == $past(wrData[5]);
   endproperty
   property p_tx;
      txGo |=> statWord[ST_TRX] && cmd_r.ev == PAT_IDLE && cmd_r.data == $past(wrData[7:0]);
   endproperty
   property p_trx;
      statWord[ST_TRX] |-> ctlWord[4:0] == PAT_IDLE;
   endproperty
   property p_rbf;
      rdRx && !rxDone |=> !rxFull_r;
   endproperty
   property p_irq;
      s_done |-> master_event_irq ##1 (cmd_r.ev == PAT_IDLE && !cmd_r.tx);
   endproperty
   property p_noq;
      wrCtl && busy && !doneCore |=> cmd_r.ev == $past(cmd_r.ev);
   endproperty
   property p_wcol;
      txCol && !doneCore |=> wcol_r && cmd_r.data == $past(cmd_r.data);
   endproperty
   property p_rx;
      s_rx_end |=> rxFull_r && !cmd_r.ev[BIT_RECV] && rxData_r == $past(res.rxByte);
   endproperty

   a_start: assert property (p_start) else $error("start pattern");
   a_restart: assert property (p_restart) else $error("restart pattern");
   a_stop: assert property (p_stop) else $error("stop pattern");
   a_recv: assert property (p_recv) else $error("receive pattern");
   a_ack: assert property (p_ack) else $error("ack pattern");
   a_tx: assert property (p_tx) else $error("transmit start");
   a_trx: assert property (p_trx) else $error("transmit flag");
   a_rbf: assert property (p_rbf) else $error("full not cleared");
   a_irq: assert property (p_irq) else $error("completion");
   a_noq: assert property (p_noq) else $error("event queued");
   a_wcol: assert property (p_wcol) else $error("collision");
   a_rx: assert property (p_rx) else $error("receive end");
endmodule : ims_msg_seq

// file: dv/ims_slave_model.sv
`timescale 1ns/1ps
// ***********************************
// Serial slave at the far end of the bus
// ***********************************
module ims_slave_model
(
   input wire logic scl,
   input wire logic sda,
   input wire logic nack,
   input wire logic stretch,
   input wire logic [7:0] txByte,
   output logic sclPull,
   output logic sdaPull,
   output logic [7:0] gotByte
);
   int bitCnt = 0;
   logic addrPhase = 1'b0;
   logic sending = 1'b0;
   logic masterAck = 1'b0;
   logic [7:0] shiftIn = 8'h00;

   initial
   begin
      sclPull = 1'b0;
      sdaPull = 1'b0;
      gotByte = 8'h00;
   end

   // Start and stop are only legal edges of data while the clock is high
   always @(negedge sda)
   begin
      if (scl)
      begin
         bitCnt = 0;
         addrPhase = 1'b1;
         sending = 1'b0;
      end
   end

   always @(posedge sda)
   begin
      if (scl)
      begin
         addrPhase = 1'b0;
         sending = 1'b0;
         sdaPull = 1'b0;
      end
   end

   always @(posedge scl)
   begin
      if (bitCnt < 8)
         shiftIn = {shiftIn[6:0], sda};
      else
         masterAck = !sda;
      bitCnt++;
   end

   // Data changes only while the clock is low
   always @(negedge scl)
   begin
      if (bitCnt == 8)
      begin
         gotByte = shiftIn;
         sdaPull = !sending && !nack;
      end
      else if (bitCnt == 9)
      begin
         sending = addrPhase ? shiftIn[0] : (sending && masterAck);
         addrPhase = 1'b0;
         bitCnt = 0;
         sdaPull = sending && !txByte[7];
      end
      else if (sending && bitCnt != 0)
         sdaPull = !txByte[7 - bitCnt];
   end

   // Slow slave: holds the clock low after each falling edge
   always @(negedge scl)
   begin
      if (stretch)
      begin
         sclPull = 1'b1;
         #500;
         sclPull = 1'b0;
      end
   end
endmodule : ims_slave_model

// file: dv/ims_msg_seq_tb.sv
`timescale 1ns/1ps
module ims_msg_seq_tb;
   import ims_pkg::*;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [AW-1:0] regAddr = '0;
   logic [DW-1:0] wrData = '0;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic nack = 1'b0;
   logic stretch = 1'b0;
   logic [DW-1:0] rdData, rd;
   logic master_event_irq, sclOe, sdaOe, sclPull, sdaPull, sdaAtRise;
   logic [7:0] gotByte;
   int num_errors = 0;
   int samples_checked = 0;
   int irqCount = 0;
   int expIrq = 0;
   int cycles = 0;
   // Open-drain lines with pull-ups
   wire sclLine = !sclOe && !sclPull;
   wire sdaLine = !sdaOe && !sdaPull;

   always #50 core_clk = ~core_clk;
   initial
   begin
      #17;
      forever #32 link_clk = ~link_clk;
   end

   ims_msg_seq u_ims_msg_seq (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .master_event_irq(master_event_irq), .link_clk(link_clk),
      .serial_clock_line_in(sclLine), .serial_clock_line_out(), .serial_clock_line_oe(sclOe),
      .serial_data_line_in(sdaLine), .serial_data_line_out(), .serial_data_line_oe(sdaOe));

   ims_slave_model u_ims_slave_model (.scl(sclLine), .sda(sdaLine), .nack(nack),
      .stretch(stretch), .txByte(8'h96), .sclPull(sclPull), .sdaPull(sdaPull),
      .gotByte(gotByte));

   always @(posedge sclLine) sdaAtRise = sdaLine;

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (master_event_irq === 1'b1)
         irqCount <= irqCount + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   task automatic summarize();
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("FAIL %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask : check

   // ***********************************
   // Register bus, one idle cycle between accesses
   // ***********************************
   task automatic regWrite(input logic [AW-1:0] a, input logic [DW-1:0] d);
      regAddr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge core_clk);
      wrStb <= 1'b0;
      @(posedge core_clk);
   endtask : regWrite

   task automatic regRead(input logic [AW-1:0] a, output logic [DW-1:0] d);
      regAddr <= a;
      rdStb <= 1'b1;
      @(posedge core_clk);
      rdStb <= 1'b0;
      @(posedge core_clk);
      d = rdData;
   endtask : regRead

   task automatic readCheck(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string n);
      logic [DW-1:0] d;
      regRead(a, d);
      check(n, d, exp);
   endtask : readCheck

   task automatic waitIrq();
      int n;
      expIrq++;
      n = 0;
      while (irqCount < expIrq && n < 3000)
      begin
         @(posedge core_clk);
         n++;
      end
      @(posedge core_clk);
      check("irq count", DW'(irqCount), DW'(expIrq));
   endtask : waitIrq

   // Event with pattern check while running; poke tries forbidden writes
   task automatic runEvent(input logic [DW-1:0] word, input bit poke);
      logic [DW-1:0] d;
      regWrite(ADDR_CTL, word);
      readCheck(ADDR_CTL, {10'h000, word[5:0]}, "ctl pattern");
      if (poke)
      begin
         regWrite(ADDR_CTL, {11'h000, PAT_STOP});
         readCheck(ADDR_CTL, {10'h000, word[5:0]}, "ctl queued");
         regWrite(ADDR_TX, 16'h0055);
         regRead(ADDR_STAT, d);
         check("collision", {14'h0000, d[ST_WCOL], d[ST_TRX]}, 16'h0002);
         regWrite(ADDR_STAT, 16'h0080);
      end
      waitIrq();
      regRead(ADDR_CTL, d);
      check("ctl idle", {11'h000, d[4:0]}, {11'h000, PAT_IDLE});
   endtask : runEvent

   task automatic sendByte(input logic [7:0] b, input logic expNack);
      logic [DW-1:0] d;
      regWrite(ADDR_TX, {8'h00, b});
      regRead(ADDR_STAT, d);
      check("tx busy", {14'h0000, d[ST_TRX], d[ST_TBF]}, 16'h0003);
      readCheck(ADDR_CTL, 16'h0000, "ctl in tx");
      waitIrq();
      check("byte on wire", {8'h00, gotByte}, {8'h00, b});
      regRead(ADDR_STAT, d);
      check("tx done", {14'h0000, d[ST_SLAVE_ACK_RECEIVED], d[ST_TRX]}, {14'h0000, expNack, 1'b0});
   endtask : sendByte

   // ***********************************
   // Message: start, write, restart, read two bytes, stop
   // ***********************************
   initial
   begin
      repeat (16) @(posedge core_clk);
      check("rdData in reset", rdData, 16'h0000);
      check("oe in reset", {14'h0000, sclOe, sdaOe}, 16'h0000);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      readCheck(ADDR_BRG, {7'h00, BRG_RST}, "baud reset");
      regWrite(ADDR_BRG, 16'h0006);
      readCheck(ADDR_BRG, 16'h0006, "baud reload");
      regWrite(3'h5, 16'hffff);
      readCheck(3'h5, 16'h0000, "unmapped");
      readCheck(ADDR_STAT, 16'h0000, "status reset");
      runEvent({11'h000, PAT_START}, 1'b0);
      check("lines after start", {14'h0000, sclLine, sdaLine}, 16'h0000);
      sendByte(8'ha0, 1'b0);
      stretch <= 1'b1;
      nack <= 1'b1;
      sendByte(8'h3c, 1'b1);
      stretch <= 1'b0;
      nack <= 1'b0;
      runEvent({11'h000, PAT_RSTART}, 1'b0);
      sendByte(8'ha1, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         runEvent({11'h000, PAT_RECV}, i == 0);
         readCheck(ADDR_TX, 16'h00a1, "tx kept");
         regRead(ADDR_STAT, rd);
         check("rx full", {15'h0000, rd[ST_RBF]}, 16'h0001);
         readCheck(ADDR_RX, 16'h0096, "rx byte");
         regRead(ADDR_STAT, rd);
         check("rx full cleared", {15'h0000, rd[ST_RBF]}, 16'h0000);
         runEvent({10'h000, i[0], PAT_ACK}, 1'b0);
         check("ack level", {15'h0000, sdaAtRise}, {15'h0000, i[0]});
      end
      runEvent({11'h000, PAT_STOP}, 1'b0);
      check("lines after stop", {14'h0000, sclLine, sdaLine}, 16'h0003);
      summarize();
   end
endmodule : ims_msg_seq_tb
